//--- ps2r_dec_if.sv
// Purpose: carries a scan code to the digit decoder and segments back
// Assumes: used only between the receiver and its decoder
// Notes: purely combinational path
`timescale 1ns/10ps
`default_nettype none
interface ps2r_dec_if;
    import ps2r_pkg::*;
    logic [CODE_W-1:0] code; // low byte of the shift register
    logic [SEG_W-1:0] segs; // decoded active-low pattern
    modport user (output code, input segs);
    modport decoder (input code, output segs);
endinterface
`default_nettype wire

//--- ps2r_digit_dec.sv
// Purpose: maps a digit key scan code to a seven-segment pattern
// Assumes: active-low segments, bit 6 is segment a
// Notes: any unknown code shows the letter E
`timescale 1ns/10ps
`default_nettype none
module ps2r_digit_dec
    import ps2r_pkg::*;
(
    // code in, segments out
    ps2r_dec_if.decoder dec
);
    // table lookup, default is E
    always_comb begin
        case (dec.code)
            KEY_1: dec.segs = SEG_1;
            KEY_2: dec.segs = SEG_2;
            KEY_3: dec.segs = SEG_3;
            KEY_4: dec.segs = SEG_4;
            KEY_5: dec.segs = SEG_5;
            KEY_6: dec.segs = SEG_6;
            KEY_7: dec.segs = SEG_7;
            KEY_8: dec.segs = SEG_8;
            KEY_9: dec.segs = SEG_9;
            KEY_0: dec.segs = SEG_0;
            default: dec.segs = SEG_E;
        endcase
    end
endmodule // ps2r_digit_dec
`default_nettype wire

//--- ps2r_kbd_model.sv
// Purpose: behavioural keyboard that sends scan code frames
// Assumes: 48 ns bit period, clock and data lines pulled up
// Notes: both lines idle high between frames, clock stands still then
`timescale 1ns/10ps
`default_nettype none
module ps2r_kbd_model (
    // lines driven by the keyboard
    output logic kclk,
    output logic kdata,
    // resolved level of the shared clock line
    input wire logic line_clk
);
    // lines idle high through their pull-ups
    initial begin
        kclk = 1'b1;
        kdata = 1'b1;
    end
    // sends the first nbits of a frame, start bit first
    task automatic send(input logic [7:0] code, input int nbits);
        logic [10:0] frame; // stop, odd parity, code, start
        frame = {1'b1, ~^code, code, 1'b0};
        wait (line_clk === 1'b1);
        for (int i = 0; i < nbits; i++) begin
            kdata = frame[i];
            #12;
            kclk = 1'b0;
            #24;
            kclk = 1'b1;
            #12;
        end
        kdata = 1'b1; // released, pull-up wins
    endtask
endmodule // ps2r_kbd_model
`default_nettype wire

//--- ps2r_pkg.sv
// Purpose: shared constants for the keyboard scan code receiver
// Assumes: one system clock at 250 MHz, keyboard lines sampled
// Notes: segment patterns are active low, bit 6 is segment a
package ps2r_pkg;
    // frame and register shape
    localparam int SHIFT_W = 10;
    localparam int CODE_W = 8;
    localparam int SEG_W = 7;
    localparam int FRAME_BITS = 11;
    localparam int CNT_W = 4;
    // values after reset
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 10'h000;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    // scan codes of digit keys
    localparam logic [CODE_W-1:0] KEY_1 = 8'h16;
    localparam logic [CODE_W-1:0] KEY_2 = 8'h1E;
    localparam logic [CODE_W-1:0] KEY_3 = 8'h26;
    localparam logic [CODE_W-1:0] KEY_4 = 8'h25;
    localparam logic [CODE_W-1:0] KEY_5 = 8'h2E;
    localparam logic [CODE_W-1:0] KEY_6 = 8'h36;
    localparam logic [CODE_W-1:0] KEY_7 = 8'h3D;
    localparam logic [CODE_W-1:0] KEY_8 = 8'h3E;
    localparam logic [CODE_W-1:0] KEY_9 = 8'h46;
    localparam logic [CODE_W-1:0] KEY_0 = 8'h45;
    // active-low digit patterns
    localparam logic [SEG_W-1:0] SEG_1 = 7'h6D;
    localparam logic [SEG_W-1:0] SEG_2 = 7'h22;
    localparam logic [SEG_W-1:0] SEG_3 = 7'h24;
    localparam logic [SEG_W-1:0] SEG_4 = 7'h45;
    localparam logic [SEG_W-1:0] SEG_5 = 7'h14;
    localparam logic [SEG_W-1:0] SEG_6 = 7'h10;
    localparam logic [SEG_W-1:0] SEG_7 = 7'h2D;
    localparam logic [SEG_W-1:0] SEG_8 = 7'h00;
    localparam logic [SEG_W-1:0] SEG_9 = 7'h04;
    localparam logic [SEG_W-1:0] SEG_0 = 7'h08;
    localparam logic [SEG_W-1:0] SEG_E = 7'h12;
    localparam logic [SEG_W-1:0] SEG_RST = 7'h7F;
endpackage

//--- ps2r_receiver.sv
// Purpose: receives keyboard scan code frames and shows them on LEDs
// Assumes: keyboard clock far slower than the system clock
// Notes: no parity or framing checks; display follows raw shift contents
//        the frame length is a parameter, the shift register width is fixed
//        the bit counter only steers when an inhibit request may start
//        keyboard_clock_out is always low; the line is pulled only while
//        keyboard_clock_oe_n is low, in the manner of an open-drain pin
//        our own pull of the clock line is never taken as a keyboard edge
// How it works
// - receiver may hold clock low between frames
// - each falling edge shifts data into top
// - after eleven edges low byte holds code
// - bargraph shows inverted low byte
// - bargraph follows shifting without extra delay
// - digit keys show numeral, otherwise E
// - controller reset and RAM enable held high
// - keyboard clock conditioned before use
// - decode digit make codes to fixed patterns
`timescale 1ns/10ps
`default_nettype none
module ps2r_receiver
    import ps2r_pkg::*;
#(
    parameter int FRAME_LEN = FRAME_BITS // falling edges per frame
) (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // keyboard lines
    input wire logic keyboard_clock_in,
    input wire logic keyboard_serial_in,
    output logic keyboard_clock_out,
    output logic keyboard_clock_oe_n,
    // local request to inhibit the keyboard
    input wire logic inhibit,
    // displays
    output logic [CODE_W-1:0] bargraph_segments_n,
    output logic [SEG_W-1:0] digit_segments_n,
    // neighbouring chips
    output logic uc_reset,
    output logic ram_oe_n
);
    // the counter must hold a whole frame
    // a frame shorter than two edges has no room for start and stop
    // a frame longer than fifteen edges is refused, to keep within the four-bit counter
    if (FRAME_LEN < 2 || FRAME_LEN > 15) begin : g_bad_len
        $error("FRAME_LEN out of range");
    end

    // counter value of the stop bit, after which the count wraps
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_LEN - 1);

    // all state of the receiver
    typedef struct packed {
        logic clk_s1; // first sync stage, clock line
        logic clk_s2; // second sync stage
        logic clk_s3; // previous value for edge detect
        logic dat_s1; // first sync stage, data line
        logic dat_s2; // second sync stage
        logic [SHIFT_W-1:0] shift; // frame shift register
        logic [CNT_W-1:0] bit_cnt; // falling edges seen in frame
        logic [CODE_W-1:0] bar; // bargraph copy
        logic [SEG_W-1:0] digit; // digit segments
        logic hold; // driving the clock line low
        logic [1:0] hold_age; // hold as the line synchroniser still sees it
        logic straps; // neighbour chip controls
    } ps2r_state_s;

    ps2r_state_s cur; // registered state
    ps2r_state_s next_cur; // next state
    logic fall; // keyboard clock falling edge
    logic own_pull; // line may read low because we hold it
    logic [SHIFT_W-1:0] next_shift; // shifted value

    // the decoder is a separate module on a small interface;
    // its segments are registered here, not in the decoder
    ps2r_dec_if dec_bus ();

    // decoder sees the current low byte
    assign dec_bus.code = cur.shift[CODE_W-1:0];

    ps2r_digit_dec u_dec (
        .dec(dec_bus.decoder)
    );

    // while we hold the clock line low the synchroniser sees it fall;
    // that edge is ours, not the keyboard's, and must not shift data.
    // hold_age covers the synchroniser stages after a short hold
    assign own_pull = cur.hold | (|cur.hold_age);

    // falling edge from synchronised samples only
    assign fall = cur.clk_s3 & ~cur.clk_s2 & ~own_pull;
    assign next_shift = {cur.dat_s2, cur.shift[SHIFT_W-1:1]};

    // timing of one keyboard bit, in system clocks:
    //   the pin falls, and two edges later the second stage holds it
    //   the edge detector then sees the fall against the third stage
    //   the next edge moves the shift register and the bargraph copy
    //   one edge after that the digit display follows the decoder
    // the keyboard clock low and high phases must each last at least
    // one system clock, or an edge slips through unseen
    // data takes the same two stages as the clock, so both stay aligned

    // next state
    always_comb begin
        next_cur = cur;
        // two-stage synchronisers
        next_cur.clk_s1 = keyboard_clock_in;
        next_cur.clk_s2 = cur.clk_s1;
        next_cur.clk_s3 = cur.clk_s2;
        next_cur.dat_s1 = keyboard_serial_in;
        next_cur.dat_s2 = cur.dat_s1;
        // shift on every falling edge, no checks
        if (fall) begin
            next_cur.shift = next_shift;
            next_cur.bar = ~next_shift[CODE_W-1:0];
            // frame position, wraps after stop bit
            if (cur.bit_cnt == LAST_BIT) begin
                next_cur.bit_cnt = CNT_RST;
            end else begin
                next_cur.bit_cnt = cur.bit_cnt + 4'h1;
            end
        end
        // digit display follows the decoder
        next_cur.digit = dec_bus.segs;
        // inhibit only between frames with the line high
        // dropping inhibit releases the line at the next edge;
        // raising it waits for the end of a frame, so no frame is cut
        if (!inhibit) begin
            next_cur.hold = 1'b0;
        end else if (cur.bit_cnt == CNT_RST && cur.clk_s2 && !fall) begin
            next_cur.hold = 1'b1;
        end
        // neighbour chips stay out of the way
        next_cur.straps = 1'b1;
        // age of our own pull, as the synchroniser still sees it
        next_cur.hold_age = {cur.hold_age[0], cur.hold};
    end

    // state register, frozen while ce is low
    // the synchroniser stages reset high, the idle level of both lines,
    // so no false falling edge follows the release of reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur <= '{clk_s1: 1'b1, clk_s2: 1'b1, clk_s3: 1'b1,
                     dat_s1: 1'b1, dat_s2: 1'b1, shift: SHIFT_RST,
                     bit_cnt: CNT_RST, bar: 8'hFF, digit: SEG_RST,
                     hold: 1'b0, hold_age: 2'h0, straps: 1'b1};
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state
    // the bargraph copy is loaded in the same edge as the shift register,
    // so it follows every bit as it arrives with no extra lag
    assign bargraph_segments_n = cur.bar;
    assign digit_segments_n = cur.digit;
    assign keyboard_clock_out = 1'b0 & cur.hold;
    assign keyboard_clock_oe_n = ~cur.hold;
    assign uc_reset = cur.straps;
    assign ram_oe_n = cur.straps;

    // checks
    // most of these watch the registered state one edge after the cause;
    // all are off while rstn is low, and most need ce high in the
    // antecedent because a frozen register would otherwise look stale
    a_shift_on_fall: assert property (@(posedge clock) disable iff (!rstn)
        (ce && fall) |=> (cur.shift == {$past(cur.dat_s2), $past(cur.shift[SHIFT_W-1:1])}))
        else $error("shift register did not take data on falling edge");
    a_bar_inverts: assert property (@(posedge clock) disable iff (!rstn)
        bargraph_segments_n == ~cur.shift[CODE_W-1:0])
        else $error("bargraph is not the inverted low byte");
    a_bar_moves: assert property (@(posedge clock) disable iff (!rstn)
        (ce && fall && next_shift[CODE_W-1:0] != cur.shift[CODE_W-1:0])
        |=> $changed(bargraph_segments_n))
        else $error("bargraph did not follow the shift");
    a_frame_wrap: assert property (@(posedge clock) disable iff (!rstn)
        (ce && fall && cur.bit_cnt == LAST_BIT) |=> (cur.bit_cnt == CNT_RST))
        else $error("frame counter did not wrap after stop bit");
    a_digit_follows: assert property (@(posedge clock) disable iff (!rstn)
        ce |=> (digit_segments_n == $past(dec_bus.segs)))
        else $error("digit display lags decoder");
    a_key_one: assert property (@(posedge clock) disable iff (!rstn)
        (ce && cur.shift[CODE_W-1:0] == 8'h16) |=> (digit_segments_n == 7'h6D))
        else $error("key 1 not shown");
    a_straps_high: assert property (@(posedge clock) disable iff (!rstn)
        uc_reset && ram_oe_n)
        else $error("neighbour controls not high");
    a_hold_idle: assert property (@(posedge clock) disable iff (!rstn)
        (ce && !cur.hold && $rose(next_cur.hold)) |-> (cur.bit_cnt == CNT_RST))
        else $error("clock held low inside a frame");
    a_still_idle: assert property (@(posedge clock) disable iff (!rstn)
        (ce && !fall) |=> $stable(cur.shift))
        else $error("shift register moved without an edge");
    a_pull_no_shift: assert property (@(posedge clock) disable iff (!rstn)
        (ce && cur.hold) |=> $stable(cur.shift))
        else $error("own clock pull was taken as a keyboard edge");
    a_release_hold: assert property (@(posedge clock) disable iff (!rstn)
        (ce && !inhibit) |=> keyboard_clock_oe_n)
        else $error("clock line held without an inhibit request");
    a_hold_mid_frame: assert property (@(posedge clock) disable iff (!rstn)
        (ce && !cur.hold && cur.bit_cnt != CNT_RST) |=> !cur.hold)
        else $error("clock line pulled inside a frame");
    a_other_shows_e: assert property (@(posedge clock) disable iff (!rstn)
        (ce && cur.shift[CODE_W-1:0] == 8'h00) |=> (digit_segments_n == SEG_E))
        else $error("non-digit code did not show the letter");
endmodule // ps2r_receiver
`default_nettype wire

//--- tb_ps2_scan_code_receiver.sv
// Purpose: self-checking bench for the scan code receiver
// Assumes: keyboard model at 48 ns per bit, system clock 4 ns
// Notes: checks are made a few clocks after each frame settles
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_ps2_scan_code_receiver;
    import ps2r_pkg::*;
    logic clock, rstn, ce, inhibit; // system side inputs
    wire logic kclk, kdata, line_clk; // keyboard lines
    logic clk_out, clk_oe_n, uc_reset, ram_oe_n; // single-bit outputs
    logic [CODE_W-1:0] bar_n; // bargraph
    logic [SEG_W-1:0] dig_n; // digit
    int fail_count, compares;
    // clock line is pulled low only while our driver is enabled
    assign line_clk = (clk_oe_n === 1'b0) ? clk_out : kclk;
    ps2r_kbd_model kbd (.kclk(kclk), .kdata(kdata), .line_clk(line_clk));
    ps2r_receiver dut (.clock(clock), .rstn(rstn), .ce(ce), .keyboard_clock_in(line_clk),
        .keyboard_serial_in(kdata), .keyboard_clock_out(clk_out),
        .keyboard_clock_oe_n(clk_oe_n), .inhibit(inhibit), .bargraph_segments_n(bar_n),
        .digit_segments_n(dig_n), .uc_reset(uc_reset), .ram_oe_n(ram_oe_n));
    // free-running system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // verdict and end of run
    task automatic results();
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock);
    endtask
    // values after reset and the held-high neighbour controls
    task automatic t_reset();
        `CHK("bargraph", 8'hFF, bar_n)
        `CHK("digit", SEG_E, dig_n)
        `CHK("uc_reset", 1'b1, uc_reset)
        `CHK("ram_oe_n", 1'b1, ram_oe_n)
        `CHK("clock_oe_n", 1'b1, clk_oe_n)
    endtask
    // every digit key, then codes that are no digit
    task automatic t_digits();
        logic [CODE_W-1:0] keys [12];
        logic [SEG_W-1:0] segs [12];
        keys = '{KEY_0, KEY_1, KEY_2, KEY_3, KEY_4, KEY_5, KEY_6, KEY_7, KEY_8, KEY_9,
            8'h00, 8'hAA};
        segs = '{SEG_0, SEG_1, SEG_2, SEG_3, SEG_4, SEG_5, SEG_6, SEG_7, SEG_8, SEG_9,
            SEG_E, SEG_E};
        for (int i = 0; i < 12; i++) begin
            kbd.send(keys[i], 11);
            wait_clk(8);
            `CHK("bargraph", ~keys[i], bar_n)
            `CHK("digit", segs[i], dig_n)
        end
    endtask
    // inhibit holds the keyboard off until it is dropped
    task automatic t_inhibit();
        inhibit = 1'b1;
        wait_clk(3);
        `CHK("clock_oe_n", 1'b0, clk_oe_n)
        `CHK("clock_out", 1'b0, clk_out)
        fork
            kbd.send(KEY_0, 11);
            begin
                wait_clk(200);
                `CHK("bargraph", ~8'hAA, bar_n)
                inhibit = 1'b0;
            end
        join
        wait_clk(8);
        `CHK("bargraph", ~KEY_0, bar_n)
        `CHK("clock_oe_n", 1'b1, clk_oe_n)
    endtask
    // three bits of a new frame shift the old contents down
    task automatic t_partial();
        kbd.send(KEY_0, 3);
        wait_clk(8);
        `CHK("bargraph", ~{1'b0, 1'b1, ~^KEY_0, KEY_0[7:3]}, bar_n)
        `CHK("digit", SEG_E, dig_n)
    endtask
    // a low clock enable freezes every register, so a whole frame is lost
    task automatic t_freeze();
        ce = 1'b0;
        kbd.send(KEY_1, 11);
        wait_clk(8);
        `CHK("bargraph", ~{1'b0, 1'b1, ~^KEY_0, KEY_0[7:3]}, bar_n)
        `CHK("digit", SEG_E, dig_n)
        ce = 1'b1;
        wait_clk(8);
        `CHK("bargraph", ~{1'b0, 1'b1, ~^KEY_0, KEY_0[7:3]}, bar_n)
    endtask
    // main sequence
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        inhibit = 1'b0;
        fail_count = 0;
        compares = 0;
        wait_clk(2);
        rstn = 1'b1;
        wait_clk(2);
        t_reset();
        t_digits();
        t_inhibit();
        t_partial();
        t_freeze();
        results();
    end
    // watchdog well beyond the expected run of about 10 us
    initial begin
        #100000;
        fail_count++;
        results();
    end
endmodule // tb_ps2_scan_code_receiver
`default_nettype wire
